// ---- hw/pabp_pkg.sv ----
// package: constants and types for the parallel asynchronous buffer port
package pabp_pkg;
    localparam int FIFO_BYTES = 8;
    localparam int ADDR_W = 10;
    localparam logic [1:0] SEL_STATUS = 2'h2;
    localparam logic [1:0] SEL_DATA = 2'h3;
    localparam int SINGLE_BIT = 7;
    localparam int PAGE_BITS = 2;
    localparam int ST_ZERO_POWER = 7;
    localparam int ST_LOW_POWER = 6;
    localparam int ST_PKT_INT = 4;
    localparam int ST_FIFO_EMPTY = 2;
    localparam int ST_FRAME_SYNC = 1;
    localparam int ST_BUSY = 0;
    localparam int BYTE_IDX_POS = 0;
    localparam int BYTE_IDX_PAGE = 1;
    localparam int BYTE_IDX_SINGLE = 2;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [9:0] BLOCK_STEP = 10'h008;
    localparam int PROC_NS = 40;
    localparam int CLK_NS = 4;
    localparam int PROC_CYCLES = (PROC_NS + CLK_NS - 1) / CLK_NS;
    typedef enum logic [1:0] {PABP_IDLE, PABP_WMEM, PABP_RMEM, PABP_HOLD} pabp_state_type;
endpackage

// ---- hw/pabp_mem_if.sv ----
// interface: memory access path between the port and its memory
`timescale 1ns/10ps
interface pabp_mem_if;
    logic we;
    logic [9:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    modport port (output we, output addr, output wdata, input rdata);
    modport mem (input we, input addr, input wdata, output rdata);
endinterface

// ---- hw/pabp_mem.sv ----
// module: flip-flop memory of four 256-byte pages behind the port
`timescale 1ns/10ps
module pabp_mem
    import pabp_pkg::*;
#(
    parameter int DEPTH = 1024
) (
    input wire logic clk,
    input wire logic rstn,
    pabp_mem_if.mem bus
);
    logic [7:0] store [DEPTH];

    // no reset on storage, contents are undefined until written
    always_ff @(posedge clk) begin
        if (bus.we) begin
            store[bus.addr] <= bus.wdata;
        end
    end

    assign bus.rdata = store[bus.addr];
endmodule

// ---- hw/pabp_top.sv ----
// module: parallel asynchronous source port with eight byte fifo
// Operation
// RULE1: every transfer moves eight fifo bytes
// RULE2: handshake high after eight; only status read
// RULE3: tx interrupt when sent, status ready, buffer free
// RULE4: rx interrupt on complete valid packet
// RULE5: host writes packets only while locked
// RULE6: page byte low bits page, bit7 single
// RULE7: offset byte spans full page
// RULE8: fifo byte n maps to pointer plus n
// RULE9: host checks handshake before writing fifo
// RULE10: byte captured on write strobe rising edge
// RULE11: handshake high until fifo processing done
// RULE12: writes fill fifo in reverse order
// RULE13: pointer load: six fillers, page, offset
// RULE14: select 11 block writes, pointer auto-increments
// RULE15: host waits handshake low after pointer load
// RULE16: single write stores only one data byte
// RULE17: host waits handshake low before reading
// RULE18: read strobe falling edge presents next byte
// RULE19: reads output last fifo byte first
// RULE20: select 10 read returns status register
// RULE21: status bit layout, reserved bits zero
// RULE22: no stream data path in this mode
// RULE23: status bit 0 mirrors handshake
// RULE24: fifo empty flag signals ready for eight
// RULE25: mode strapped from pins at reset release
// RULE26: address is page bits with offset, plus eight
`timescale 1ns/10ps
module pabp_top
    import pabp_pkg::*;
#(
    parameter int PROC_WAIT = PROC_CYCLES
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [1:0] port_select,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe,
    output logic fifo_handshake,
    output logic packet_interrupt_n,
    input wire logic parallel_source_select,
    input wire logic mode_select_a,
    input wire logic zero_power_flag,
    input wire logic low_power_flag,
    input wire logic frame_sync_pin,
    input wire logic tx_packet_sent,
    input wire logic tx_status_ready,
    input wire logic tx_buffer_free,
    input wire logic rx_packet_done,
    input wire logic rx_addr_match,
    input wire logic rx_crc_ok,
    input wire logic pkt_int_clear,
    output logic mode_select_a_mode
);
    typedef struct packed {
        pabp_state_type state;
        logic [7:0][7:0] fifo;
        logic [2:0] count;
        logic [2:0] step;
        logic [9:0] addr;
        logic loaded;
        logic handshake;
        logic [7:0] dout;
        logic oe;
        logic pkt_int_n;
        logic rd_d;
        logic wr_d;
        logic strapped;
        logic mode;
        logic [7:0] wait_cnt;
        logic single;
        logic [7:0] status;
    } pabp_regs_type;

    pabp_regs_type cur_reg, cur_next;
    pabp_mem_if mbus ();

    pabp_mem #(.DEPTH(1 << ADDR_W)) u_mem (
        .clk(clk),
        .rstn(rstn),
        .bus(mbus)
    );

    // build the status byte from live flags
    function automatic logic [7:0] status_byte(input logic zp, input logic lp,
                                               input logic pi, input logic empty,
                                               input logic fs, input logic busy);
        logic [7:0] s;
        s = STATUS_RESET;
        s[ST_ZERO_POWER] = zp;
        s[ST_LOW_POWER] = lp;
        s[ST_PKT_INT] = pi;
        s[ST_FIFO_EMPTY] = empty;
        s[ST_FRAME_SYNC] = fs;
        s[ST_BUSY] = busy;
        return s;
    endfunction

    logic wr_rise;
    logic rd_fall;
    logic tx_event;
    logic rx_event;
    assign wr_rise = wr_n & ~cur_reg.wr_d;
    assign rd_fall = ~rd_n & cur_reg.rd_d;
    assign tx_event = tx_packet_sent & tx_status_ready & tx_buffer_free; // see RULE3
    assign rx_event = rx_packet_done & rx_addr_match & rx_crc_ok; // see RULE4

    // memory port driven from the current processing step
    always_comb begin
        mbus.we = 1'b0;
        mbus.addr = cur_reg.addr + {7'h00, cur_reg.step}; // see RULE8
        mbus.wdata = cur_reg.fifo[cur_reg.step];
        if (cur_reg.state == PABP_WMEM) begin
            mbus.we = 1'b1;
            if (cur_reg.single) begin
                // only the byte just above the pointer bytes is stored, see RULE16
                mbus.addr = cur_reg.addr;
                mbus.wdata = cur_reg.fifo[BYTE_IDX_SINGLE];
            end
        end
    end

    // next state: strobes, fifo, pointer and handshake
    always_comb begin
        cur_next = cur_reg;
        cur_next.rd_d = rd_n;
        cur_next.wr_d = wr_n;
        cur_next.oe = ~rd_n & cur_reg.mode;
        // strap caught on the first clock after reset release, see RULE25
        if (!cur_reg.strapped) begin
            cur_next.strapped = 1'b1;
            cur_next.mode = parallel_source_select & mode_select_a;
        end
        // set wins over clear; kept active low so the pin leaves a flop directly
        if (pkt_int_clear) begin
            cur_next.pkt_int_n = 1'b1;
        end
        if (tx_event || rx_event) begin
            cur_next.pkt_int_n = 1'b0;
        end
        case (cur_reg.state)
            PABP_IDLE: begin
                if (cur_reg.mode && wr_rise && port_select[1]) begin
                    // shift in so the last byte written sits in byte 0, see RULE12
                    cur_next.fifo = {cur_reg.fifo[6:0], data_in}; // see RULE10
                    cur_next.count = cur_reg.count + 3'h1;
                    if (cur_reg.count == 3'h7) begin
                        // eighth byte closes the transfer, see RULE1
                        cur_next.count = 3'h0;
                        cur_next.handshake = 1'b1; // see RULE11
                        cur_next.step = 3'h0;
                        if (port_select == SEL_STATUS) begin
                            // pointer load; page and offset form the address, see RULE26
                            cur_next.addr = {cur_reg.fifo[0][PAGE_BITS-1:0], data_in}; // see RULE6
                            cur_next.single = cur_reg.fifo[0][SINGLE_BIT];
                            cur_next.loaded = 1'b1; // see RULE7
                            cur_next.state = cur_reg.fifo[0][SINGLE_BIT] ? PABP_WMEM
                                                                         : PABP_HOLD;
                        end else begin
                            cur_next.single = 1'b0;
                            cur_next.state = PABP_WMEM; // see RULE14
                        end
                        cur_next.wait_cnt = 8'h00;
                    end
                end else if (cur_reg.mode && rd_fall && port_select == SEL_DATA) begin
                    // highest fifo byte leaves first, see RULE19
                    cur_next.dout = cur_reg.fifo[7]; // see RULE18
                    cur_next.fifo = {cur_reg.fifo[6:0], 8'h00};
                    cur_next.count = cur_reg.count + 3'h1;
                    if (cur_reg.count == 3'h7) begin
                        cur_next.count = 3'h0;
                        cur_next.handshake = 1'b1; // see RULE2
                        cur_next.step = 3'h0;
                        cur_next.addr = cur_reg.addr + BLOCK_STEP; // see RULE26
                        cur_next.state = PABP_RMEM;
                        cur_next.wait_cnt = 8'h00;
                    end
                end
            end
            PABP_WMEM: begin
                // one memory byte per clock; the pointer carries from offset into page bits and wraps at the top of memory
                cur_next.step = cur_reg.step + 3'h1;
                if (cur_reg.single || cur_reg.step == 3'h7) begin
                    if (!cur_reg.single) begin
                        cur_next.addr = cur_reg.addr + BLOCK_STEP; // see RULE14
                    end
                    cur_next.step = 3'h0;
                    cur_next.state = PABP_RMEM;
                end
            end
            PABP_RMEM: begin
                // prefetch the next block so a read can follow any write
                cur_next.fifo[cur_reg.step] = mbus.rdata; // see RULE8
                cur_next.step = cur_reg.step + 3'h1;
                if (cur_reg.step == 3'h7) begin
                    cur_next.state = PABP_HOLD;
                end
            end
            default: begin
                // minimum busy time before the fifo reopens, see RULE11
                cur_next.wait_cnt = cur_reg.wait_cnt + 8'h01;
                if (cur_reg.wait_cnt >= 8'(PROC_WAIT - 1)) begin
                    if (cur_reg.single || !cur_reg.loaded) begin
                        cur_next.single = 1'b0;
                    end
                    cur_next.handshake = 1'b0;
                    cur_next.state = PABP_IDLE;
                end
            end
        endcase
        // pointer load also prefetches its block for the first read, see RULE15
        if (cur_reg.state == PABP_HOLD && cur_reg.wait_cnt == 8'h00 && cur_reg.step == 3'h0
            && cur_reg.handshake && !cur_reg.single) begin
            cur_next.state = PABP_RMEM;
        end
        // status stays readable in every state, busy included, see RULE2
        if (cur_reg.mode && rd_fall && port_select == SEL_STATUS) begin
            cur_next.dout = cur_reg.status; // see RULE20
        end
        // the stream path is absent; only memory is reached, see RULE22
        cur_next.status = status_byte(zero_power_flag, low_power_flag, ~cur_next.pkt_int_n,
                                      cur_next.state == PABP_IDLE && cur_next.count == 3'h0,
                                      frame_sync_pin, cur_next.handshake); // see RULE21
        // see RULE23 and RULE24: bits 0 and 2 follow handshake and empty
    end

    // single register stage for all state; outputs come straight from it
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cur_reg <= '0;
            // leave reset busy one clock short of the processing time, then open the fifo;
            // a nonzero count keeps the pointer prefetch from firing unloaded
            cur_reg.state <= PABP_HOLD;
            cur_reg.wait_cnt <= 8'h01;
            cur_reg.pkt_int_n <= 1'b1;
            cur_reg.rd_d <= 1'b1;
            cur_reg.wr_d <= 1'b1;
            cur_reg.handshake <= 1'b1;
            cur_reg.status <= STATUS_RESET;
        end else begin
            cur_reg <= cur_next;
        end
    end

    assign data_out = cur_reg.dout;
    assign data_oe = cur_reg.oe;
    assign fifo_handshake = cur_reg.handshake; // see RULE2
    assign packet_interrupt_n = cur_reg.pkt_int_n; // see RULE3
    assign mode_select_a_mode = cur_reg.mode;
endmodule

// ---- tb/pabp_monitor.sv ----
// checker: concurrent assertions on the buffer port pins
`timescale 1ns/10ps
module pabp_monitor
    import pabp_pkg::*;
#(
    parameter int PROC_WAIT = PROC_CYCLES
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [1:0] port_select,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic data_oe,
    input wire logic fifo_handshake,
    input wire logic packet_interrupt_n,
    input wire logic tx_packet_sent,
    input wire logic tx_status_ready,
    input wire logic tx_buffer_free,
    input wire logic rx_packet_done,
    input wire logic rx_addr_match,
    input wire logic rx_crc_ok,
    input wire logic pkt_int_clear
);
    localparam int HS_MAX = 40 + PROC_WAIT;
    logic wr_reg;
    logic rd_reg;
    logic stb;
    logic tx_all;
    logic rx_all;
    logic [3:0] cnt_reg;
    logic [3:0] cnt_next;
    // strobe edges as the port sees them; status reads do not count
    assign stb = (wr_n && !wr_reg) || (!rd_n && rd_reg && port_select == SEL_DATA);
    assign cnt_next = fifo_handshake ? 4'h0 : (stb ? cnt_reg + 4'h1 : cnt_reg);
    assign tx_all = tx_packet_sent && tx_status_ready && tx_buffer_free;
    assign rx_all = rx_packet_done && rx_addr_match && rx_crc_ok;
    // strobe history and count of strobes taken while the fifo is free
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wr_reg <= 1'b1;
            rd_reg <= 1'b1;
            cnt_reg <= 4'h0;
        end else begin
            wr_reg <= wr_n;
            rd_reg <= rd_n;
            cnt_reg <= cnt_next;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    sequence tx_ready;
        tx_packet_sent && tx_status_ready && tx_buffer_free;
    endsequence
    sequence rx_valid;
        rx_packet_done && rx_addr_match && rx_crc_ok;
    endsequence
    sequence hs_done;
        ##[1:HS_MAX] !fifo_handshake;
    endsequence
    chk_int_tx: assert property (tx_ready |=> !packet_interrupt_n)
        else $error("transmit event left interrupt idle");
    chk_int_rx: assert property (rx_valid |=> !packet_interrupt_n)
        else $error("receive event left interrupt idle");
    chk_int_clear: assert property (pkt_int_clear && !tx_all && !rx_all |=> packet_interrupt_n)
        else $error("interrupt not cleared");
    chk_int_quiet: assert property (packet_interrupt_n && !tx_all && !rx_all |=> packet_interrupt_n)
        else $error("interrupt without a valid event");
    chk_oe_read: assert property ($rose(data_oe) |-> $past(rd_n) == 1'b0)
        else $error("bus driven without read strobe");
    chk_hs_reset: assert property ($rose(rstn) |-> fifo_handshake)
        else $error("handshake low after reset");
    chk_hs_after_eight: assert property (stb && cnt_reg == 4'h7 |-> ##[1:2] fifo_handshake)
        else $error("handshake missing after eighth strobe");
    chk_hs_count: assert property ($rose(fifo_handshake) |-> $past(cnt_reg) >= 4'h7)
        else $error("handshake before eight strobes");
    chk_hs_release: assert property ($rose(fifo_handshake) |-> hs_done)
        else $error("handshake stuck high");
endmodule
bind pabp_top pabp_monitor #(.PROC_WAIT(PROC_WAIT)) u_monitor (.clk(clk), .rstn(rstn),
    .port_select(port_select), .rd_n(rd_n), .wr_n(wr_n), .data_oe(data_oe),
    .fifo_handshake(fifo_handshake), .packet_interrupt_n(packet_interrupt_n),
    .tx_packet_sent(tx_packet_sent), .tx_status_ready(tx_status_ready),
    .tx_buffer_free(tx_buffer_free), .rx_packet_done(rx_packet_done),
    .rx_addr_match(rx_addr_match), .rx_crc_ok(rx_crc_ok), .pkt_int_clear(pkt_int_clear));

// ---- tb/pabp_host.sv ----
// host model: drives the parallel strobes toward the port
`timescale 1ns/10ps
module pabp_host (
    input wire logic clk,
    output logic [1:0] port_select,
    output logic rd_n,
    output logic wr_n,
    output logic [7:0] data_in,
    input wire logic [7:0] data_out
);
    initial begin
        port_select = 2'h3;
        rd_n = 1'b1;
        wr_n = 1'b1;
        data_in = 8'h00;
    end
    // one write; byte held across the strobe rise, then the bus shows a flipped value
    // lock is not modelled: the host writes as if the node is locked
    task automatic wr(input logic [1:0] sel, input logic [7:0] d);
        port_select <= sel;
        data_in <= d;
        wr_n <= 1'b0;
        repeat (2) @(posedge clk);
        wr_n <= 1'b1;
        repeat (2) @(posedge clk);
        data_in <= ~d;
        @(posedge clk);
    endtask
    // one read; byte taken well after the fall so the port has settled
    task automatic rd(input logic [1:0] sel, output logic [7:0] d);
        port_select <= sel;
        rd_n <= 1'b0;
        repeat (3) @(posedge clk);
        d = data_out;
        rd_n <= 1'b1;
        repeat (2) @(posedge clk);
    endtask
endmodule

// ---- tb/testbench.sv ----
// testbench: host scenarios for the parallel buffer port
`timescale 1ns/10ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin failures++; \
    $display("BAD %0t %h %h", $time, (a), (e)); end end
module testbench;
    import pabp_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [2:0] tx = 3'h0;
    logic [2:0] rx = 3'h0;
    logic clr = 1'b0;
    logic strap = 1'b1;
    logic zp = 1'b1;
    logic lp = 1'b0;
    logic fs = 1'b1;
    logic [1:0] port_select;
    logic rd_n;
    logic wr_n;
    logic [7:0] data_in;
    logic [7:0] data_out;
    logic hs;
    logic pin;
    logic mode;
    logic oe;
    int failures = 0;
    int checks = 0;
    always #2 clk = ~clk;
    pabp_top #(.PROC_WAIT(2)) dut (.clk(clk), .rstn(rstn), .port_select(port_select),
        .rd_n(rd_n), .wr_n(wr_n), .data_in(data_in), .data_out(data_out), .data_oe(oe),
        .fifo_handshake(hs), .packet_interrupt_n(pin), .parallel_source_select(strap),
        .mode_select_a(strap), .zero_power_flag(zp), .low_power_flag(lp),
        .frame_sync_pin(fs), .tx_packet_sent(tx[0]), .tx_status_ready(tx[1]),
        .tx_buffer_free(tx[2]), .rx_packet_done(rx[0]), .rx_addr_match(rx[1]),
        .rx_crc_ok(rx[2]), .pkt_int_clear(clr), .mode_select_a_mode(mode));
    pabp_host host (.clk(clk), .port_select(port_select), .rd_n(rd_n), .wr_n(wr_n),
        .data_in(data_in), .data_out(data_out));
    task automatic final_report;
        if (failures == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // bounded wait for the fifo to come free
    task automatic wait_idle;
        int n;
        n = 0;
        while (hs !== 1'b0 && n < 200) begin
            @(posedge clk);
            n++;
        end
        if (n == 200) begin
            failures++;
            final_report();
        end
    endtask
    // pointer load; the sixth byte carries the data of a single write
    task automatic load_ptr(input logic [7:0] page, input logic [7:0] off, input logic [7:0] d);
        wait_idle();
        for (int i = 0; i < 5; i++) host.wr(SEL_STATUS, 8'h00);
        host.wr(SEL_STATUS, d);
        host.wr(SEL_STATUS, page);
        host.wr(SEL_STATUS, off);
        wait_idle();
    endtask
    // status is read while the block is still being processed
    task automatic blk_wr(input logic [7:0] seed);
        logic [7:0] d;
        for (int i = 0; i < 8; i++) host.wr(SEL_DATA, seed + 8'(i));
        host.rd(SEL_STATUS, d);
        `CHK(d, 8'h83)
        wait_idle();
    endtask
    // reads come back in write order: both run from the top fifo byte down
    task automatic blk_rd(input logic [7:0] seed, input int one);
        logic [7:0] d;
        for (int i = 0; i < 8; i++) begin
            host.rd(SEL_DATA, d);
            `CHK(d, (i == one) ? 8'ha5 : seed + 8'(i))
        end
        wait_idle();
    endtask
    task automatic t_blocks;
        load_ptr(8'h03, 8'hf0, 8'h00);
        blk_wr(8'h10);
        blk_wr(8'h20);
        load_ptr(8'h03, 8'hf0, 8'h00);
        blk_rd(8'h10, 9);
        blk_rd(8'h20, 9);
    endtask
    task automatic t_single;
        load_ptr(8'h83, 8'hfa, 8'ha5);
        load_ptr(8'h03, 8'hf8, 8'h00);
        blk_rd(8'h20, 5);
    endtask
    task automatic t_status(input logic [7:0] exp);
        logic [7:0] d;
        host.rd(SEL_STATUS, d);
        `CHK(d, exp)
    endtask
    // one-cycle event pulse, then the interrupt pin is judged
    task automatic pulse(input logic [2:0] t, input logic [2:0] r, input logic c, input logic e);
        tx <= t;
        rx <= r;
        clr <= c;
        @(posedge clk);
        tx <= 3'h0;
        rx <= 3'h0;
        clr <= 1'b0;
        repeat (2) @(posedge clk);
        `CHK(pin, e)
    endtask
    task automatic t_irq;
        pulse(3'h3, 3'h0, 1'b0, 1'b1);
        pulse(3'h7, 3'h0, 1'b0, 1'b0);
        t_status(8'h96);
        pulse(3'h0, 3'h0, 1'b1, 1'b1);
        pulse(3'h0, 3'h3, 1'b0, 1'b1);
        pulse(3'h0, 3'h5, 1'b0, 1'b1);
        pulse(3'h0, 3'h7, 1'b0, 1'b0);
        pulse(3'h0, 3'h0, 1'b1, 1'b1);
    endtask
    // second reset with the straps low leaves the port out of this mode
    task automatic t_strap;
        rstn <= 1'b0;
        strap <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        repeat (2) @(posedge clk);
        `CHK(mode, 1'b0)
        `CHK(pin, 1'b1)
    endtask
    initial begin
        repeat (16) @(posedge clk);
        `CHK(hs, 1'b1)
        `CHK(oe, 1'b0)
        rstn <= 1'b1;
        repeat (2) @(posedge clk);
        `CHK(mode, 1'b1)
        `CHK(hs, 1'b0)
        t_blocks();
        t_single();
        t_status(8'h86);
        t_irq();
        t_strap();
        final_report();
    end
endmodule
